//--- include/cfg_map.svh
`ifndef CFG_MAP_SVH
`define CFG_MAP_SVH
// instruction class encodings
`define CFG_CLS_OTHER      4'h0
`define CFG_CLS_NEAR_CALL  4'h1
`define CFG_CLS_FAR_CALL   4'h2
`define CFG_CLS_INT_ENTRY  4'h3
`define CFG_CLS_RETURN     4'h4
`define CFG_CLS_IND_JMP    4'h5
`define CFG_CLS_IND_CALL   4'h6
`define CFG_CLS_MARK_LEG   4'h7
`define CFG_CLS_MARK_WIDE  4'h8
`define CFG_CLS_STORE      4'h9
`define CFG_CLS_SSTK_OP    4'hA
// default widths and depth
`define CFG_ADDR_W         64
`define CFG_STK_DEPTH      16
`endif

//--- include/cfg_pkg.sv
package cfg_pkg;
	typedef enum logic [1:0] {
		CFG_IDLE         = 2'b01,
		CFG_AWAIT_MARKER = 2'b10
	} cfg_track_type;

	typedef enum logic [2:0] {
		CFG_FAULT_NONE   = 3'h0,
		CFG_FAULT_RETURN = 3'h1,
		CFG_FAULT_MARKER = 3'h2,
		CFG_FAULT_STORE  = 3'h3,
		CFG_FAULT_UNDER  = 3'h4,
		CFG_FAULT_OVER   = 3'h5
	} cfg_fault_type;

	// retired instruction from the pipeline
	typedef struct packed {
		logic        valid;
		logic [3:0]  cls;
		logic        user;
		logic [63:0] ret_addr;
		logic        page_sstk;
	} cfg_instr_type;

	// fault report towards the pipeline
	typedef struct packed {
		logic          fault;
		cfg_fault_type code;
	} cfg_report_type;
endpackage : cfg_pkg

//--- logic/cfg_stack.sv
`timescale 1ns/1ps
`include "cfg_map.svh"
module cfg_stack #(
	parameter int ADDR_W = `CFG_ADDR_W,
	parameter int DEPTH  = `CFG_STK_DEPTH
) (
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	input  wire logic              push_i,
	input  wire logic              pop_i,
	input  wire logic [ADDR_W-1:0] data_i,
	output logic      [ADDR_W-1:0] top_o,
	output logic                   empty_o,
	output logic                   full_o
);
	localparam int PW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || ADDR_W < 1) begin : g_bad_param
		$error("cfg_stack: unsupported parameters");
	end

	logic [ADDR_W-1:0] mem [DEPTH];
	logic [PW-1:0]     ptr;
	logic [PW-1:0]     next_ptr;
	logic              do_push;
	logic              do_pop;

	always_comb begin
		do_push  = push_i && !full_o;
		do_pop   = pop_i && !empty_o;
		next_ptr = ptr;
		if (do_push) begin
			next_ptr = ptr + PW'(1);
		end else if (do_pop) begin
			next_ptr = ptr - PW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ptr <= '0;
		end else begin
			ptr <= next_ptr;
		end
	end

	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem[ptr[$clog2(DEPTH)-1:0]] <= data_i;
		end
	end

	assign empty_o = (ptr == '0);
	assign full_o  = (ptr == PW'(DEPTH));
	assign top_o   = empty_o ? '0 : mem[$clog2(DEPTH)'(ptr - PW'(1))];
endmodule : cfg_stack

//--- logic/cfg_guard.sv
`timescale 1ns/1ps
`include "cfg_map.svh"
module cfg_guard #(
	parameter int ADDR_W = `CFG_ADDR_W,
	parameter int DEPTH  = `CFG_STK_DEPTH
) (
	input  wire logic                   REF_CLK_I,
	input  wire logic                   NRST_I,
	input  wire logic                   SSTK_EN_USER_I,
	input  wire logic                   SSTK_EN_SUPER_I,
	input  wire logic                   IBT_EN_I,
	input  wire cfg_pkg::cfg_instr_type INSTR_I,
	output cfg_pkg::cfg_report_type     REPORT_O,
	output logic                        STORE_BLOCK_O,
	output logic                        RETURN_OK_O,
	output logic                        AWAIT_MARKER_O,
	output logic                        SSTK_EMPTY_O
);
	import cfg_pkg::*;

	localparam int             NCLS        = 16;
	localparam int             NPRIV       = 2;
	localparam int             LW          = $clog2(DEPTH + 1);
	localparam cfg_report_type REPORT_IDLE = '{fault: 1'b0, code: CFG_FAULT_NONE};

	// compare width and stack depth the logic can serve
	if (ADDR_W > 64 || ADDR_W < 8) begin : g_bad_width
		$error("cfg_guard: ADDR_W out of range");
	end
	if (DEPTH < 2) begin : g_bad_depth
		$error("cfg_guard: DEPTH too small");
	end
	if (DEPTH > 1024) begin : g_big_depth
		$error("cfg_guard: DEPTH beyond the array budget");
	end

	// retired instruction fields
	logic              instr_valid;
	logic [3:0]        instr_cls;
	logic              instr_user;
	logic              instr_page;
	logic [ADDR_W-1:0] addr;

	// instruction decode
	logic [NCLS-1:0]   cls_hot;
	logic [NPRIV-1:0]  priv_en;
	logic [NPRIV-1:0]  priv_sel;
	logic              ss_on;
	logic              is_near_call;
	logic              is_far_call;
	logic              is_entry;
	logic              is_ind_call;
	logic              is_ind_jmp;
	logic              is_call;
	logic              is_ret;
	logic              is_leg_marker;
	logic              is_wide_marker;
	logic              is_marker;
	logic              is_ind;
	logic              is_store;

	// shadow stack handshake
	logic              push;
	logic              pop;
	logic [ADDR_W-1:0] top;
	logic              empty;
	logic              full;
	logic [ADDR_W-1:0] addr_diff;
	logic              addr_same;

	// stack depth mirror
	logic [LW-1:0]     level;
	logic [LW-1:0]     next_level;
	logic              next_empty;

	// branch tracker
	cfg_track_type     track;
	cfg_track_type     next_track;
	logic              next_await;

	// fault conditions
	logic              awaiting;
	logic              marker_miss;
	logic              store_hit;
	logic              ret_under;
	logic              ret_bad;
	logic              ret_good;
	logic              call_over;

	// report group
	cfg_report_type    next_report;
	logic              next_store_block;
	logic              next_return_ok;

	always_comb begin
		instr_valid = INSTR_I.valid;
		instr_cls   = INSTR_I.cls;
		instr_user  = INSTR_I.user;
		instr_page  = INSTR_I.page_sstk;
		// compare and push use the low ADDR_W bits only
		addr        = INSTR_I.ret_addr[ADDR_W-1:0];
	end

	// one select line per class code, valid folded in
	for (genvar k = 0; k < NCLS; k++) begin : g_cls
		assign cls_hot[k] = instr_valid && (instr_cls == 4'(k));
	end

	// bit 1 user, bit 0 supervisor
	assign priv_en = {SSTK_EN_USER_I, SSTK_EN_SUPER_I};
	for (genvar p = 0; p < NPRIV; p++) begin : g_priv
		assign priv_sel[p] = priv_en[p] && (instr_user == 1'(p));
	end

	always_comb begin
		ss_on = |priv_sel;
	end

	// class aliases
	always_comb begin
		is_near_call   = cls_hot[`CFG_CLS_NEAR_CALL];
		is_far_call    = cls_hot[`CFG_CLS_FAR_CALL];
		is_entry       = cls_hot[`CFG_CLS_INT_ENTRY];
		is_ind_call    = cls_hot[`CFG_CLS_IND_CALL];
		is_ind_jmp     = cls_hot[`CFG_CLS_IND_JMP];
		is_ret         = cls_hot[`CFG_CLS_RETURN];
		is_leg_marker  = cls_hot[`CFG_CLS_MARK_LEG];
		is_wide_marker = cls_hot[`CFG_CLS_MARK_WIDE];
		is_store       = cls_hot[`CFG_CLS_STORE];
	end

	always_comb begin
		// indirect call pushes and arms the tracker
		is_call   = is_near_call
			|| is_far_call
			|| is_entry
			|| is_ind_call;
		is_marker = is_leg_marker || is_wide_marker;
		is_ind    = is_ind_jmp || is_ind_call;
	end

	// full and empty refuse the stack move
	always_comb begin
		push = ss_on
			&& is_call
			&& !full;
		pop  = ss_on
			&& is_ret
			&& !empty;
	end

	// return-address store, one entry per open call
	cfg_stack #(
		.ADDR_W (ADDR_W),
		.DEPTH  (DEPTH)
	) u_stack (
		.clk_i   (REF_CLK_I),
		.nrst_i  (NRST_I),
		.push_i  (push),
		.pop_i   (pop),
		.data_i  (addr),
		.top_o   (top),
		.empty_o (empty),
		.full_o  (full)
	);

	// top of stack against the popped data-stack address
	for (genvar b = 0; b < ADDR_W; b++) begin : g_cmp
		assign addr_diff[b] = top[b] ^ addr[b];
	end
	assign addr_same = ~|addr_diff;

	// depth mirror keeps the empty flag exact after the last pop
	always_comb begin
		next_level = level;
		// push and pop never meet: a class is one or the other
		if (push) begin
			next_level = level + LW'(1);
		end else if (pop) begin
			next_level = level - LW'(1);
		end
		next_empty = (next_level == '0);
	end

	always_ff @(posedge REF_CLK_I) begin
		if (!NRST_I) begin
			level        <= '0;
			SSTK_EMPTY_O <= 1'b1;
		end else begin
			level        <= next_level;
			SSTK_EMPTY_O <= next_empty;
		end
	end

	// branch tracker
	always_comb begin
		next_track = track;
		unique case (track)
			CFG_IDLE: begin
				if (instr_valid && IBT_EN_I && is_ind) begin
					next_track = CFG_AWAIT_MARKER;
				end
			end
			CFG_AWAIT_MARKER: begin
				// invalid cycles keep waiting while IBT_EN_I is set
				if (!IBT_EN_I) begin
					next_track = CFG_IDLE;
				end else if (instr_valid) begin
					// any next instruction leaves; a missing marker is faulted
					next_track = CFG_IDLE;
				end
			end
		endcase
		next_await = (next_track == CFG_AWAIT_MARKER);
	end

	// await output follows the registered state
	always_ff @(posedge REF_CLK_I) begin
		if (!NRST_I) begin
			track          <= CFG_IDLE;
			AWAIT_MARKER_O <= 1'b0;
		end else begin
			track          <= next_track;
			AWAIT_MARKER_O <= next_await;
		end
	end

	// fault conditions before priority
	always_comb begin
		awaiting    = (track == CFG_AWAIT_MARKER);
		marker_miss = instr_valid
			&& IBT_EN_I
			&& awaiting
			&& !is_marker;
		// plain stores to shadow pages are blocked, enabled or not, unless a marker miss takes priority
		store_hit   = is_store
			&& instr_page;
		// return on an empty stack is refused
		ret_under   = ss_on
			&& is_ret
			&& empty;
		ret_bad     = ss_on
			&& is_ret
			&& !empty
			&& !addr_same;
		ret_good    = ss_on
			&& is_ret
			&& !empty
			&& addr_same;
		// call on a full stack is refused, no push
		call_over   = ss_on
			&& is_call
			&& full;
	end

	// marker before store before return before overflow
	always_comb begin
		next_report      = REPORT_IDLE;
		next_store_block = 1'b0;
		next_return_ok   = 1'b0;
		if (marker_miss) begin
			next_report.fault = 1'b1;
			next_report.code  = CFG_FAULT_MARKER;
		end else if (store_hit) begin
			next_store_block  = 1'b1;
			next_report.fault = 1'b1;
			next_report.code  = CFG_FAULT_STORE;
		end else if (ret_under) begin
			next_report.fault = 1'b1;
			next_report.code  = CFG_FAULT_UNDER;
		end else if (ret_bad) begin
			next_report.fault = 1'b1;
			next_report.code  = CFG_FAULT_RETURN;
		end else if (ret_good) begin
			next_return_ok = 1'b1;
		end else if (call_over) begin
			next_report.fault = 1'b1;
			next_report.code  = CFG_FAULT_OVER;
		end
	end

	// one-cycle pulses, reloaded every clock, cleared by any cycle with nothing to report
	always_ff @(posedge REF_CLK_I) begin
		if (!NRST_I) begin
			REPORT_O      <= REPORT_IDLE;
			STORE_BLOCK_O <= 1'b0;
			RETURN_OK_O   <= 1'b0;
		end else begin
			REPORT_O      <= next_report;
			STORE_BLOCK_O <= next_store_block;
			RETURN_OK_O   <= next_return_ok;
		end
	end
endmodule : cfg_guard

//--- tb/cfg_guard_props.sv
`timescale 1ns/1ps
module cfg_guard_props
	import cfg_pkg::*;
(
	input wire logic                   REF_CLK_I,
	input wire logic                   NRST_I,
	input wire logic                   SSTK_EN_USER_I,
	input wire logic                   SSTK_EN_SUPER_I,
	input wire logic                   IBT_EN_I,
	input wire cfg_pkg::cfg_instr_type INSTR_I,
	input wire cfg_pkg::cfg_report_type REPORT_O,
	input wire logic                   STORE_BLOCK_O,
	input wire logic                   RETURN_OK_O,
	input wire logic                   AWAIT_MARKER_O,
	input wire logic                   SSTK_EMPTY_O
);
	logic [3:0] c;
	logic       v;
	assign c = INSTR_I.cls;
	assign v = INSTR_I.valid;
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!NRST_I);
	sequence s_ind;
		v && IBT_EN_I && !AWAIT_MARKER_O && (c == 4'h5 || c == 4'h6);
	endsequence
	sequence s_nxt;
		AWAIT_MARKER_O && v && IBT_EN_I;
	endsequence
	AST_ARM: assert property (s_ind |=> AWAIT_MARKER_O)
		else $error("no await after indirect branch");
	AST_MISS: assert property (s_nxt ##0 (c != 4'h7 && c != 4'h8) |=>
		REPORT_O.fault && REPORT_O.code == CFG_FAULT_MARKER)
		else $error("missing marker not faulted");
	AST_LAND: assert property (s_nxt ##0 (c == 4'h7 || c == 4'h8) |=>
		!AWAIT_MARKER_O && !REPORT_O.fault)
		else $error("marker not accepted");
	AST_BLOCK: assert property (v && c == 4'h9 && INSTR_I.page_sstk
		&& !AWAIT_MARKER_O |=> STORE_BLOCK_O && REPORT_O.code == CFG_FAULT_STORE)
		else $error("store to shadow page not blocked");
	AST_UNDER: assert property (v && c == 4'h4 && !INSTR_I.user && SSTK_EN_SUPER_I
		&& SSTK_EMPTY_O && !AWAIT_MARKER_O |=> REPORT_O.code == CFG_FAULT_UNDER)
		else $error("return on empty stack not refused");
	AST_PLAIN: assert property (v && c == 4'h9 && !INSTR_I.page_sstk |=> !STORE_BLOCK_O)
		else $error("plain store blocked");
	AST_RETOK: assert property (RETURN_OK_O |-> $past(v) && $past(c) == 4'h4)
		else $error("return ok without return");
	AST_PUSH: assert property (v && c == 4'h1 && !INSTR_I.user && SSTK_EN_SUPER_I
		&& !AWAIT_MARKER_O |=> !SSTK_EMPTY_O)
		else $error("call did not push");
	AST_OFF: assert property (v && c == 4'h1 && INSTR_I.user && !SSTK_EN_USER_I
		&& SSTK_EMPTY_O |=> SSTK_EMPTY_O)
		else $error("push while user stack off");
	AST_RST: assert property (disable iff (1'b0) !NRST_I |=>
		!AWAIT_MARKER_O && SSTK_EMPTY_O && !REPORT_O.fault)
		else $error("bad reset state");
endmodule : cfg_guard_props
bind cfg_guard cfg_guard_props chk (.REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I),
	.SSTK_EN_USER_I(SSTK_EN_USER_I), .SSTK_EN_SUPER_I(SSTK_EN_SUPER_I),
	.IBT_EN_I(IBT_EN_I), .INSTR_I(INSTR_I), .REPORT_O(REPORT_O),
	.STORE_BLOCK_O(STORE_BLOCK_O), .RETURN_OK_O(RETURN_OK_O),
	.AWAIT_MARKER_O(AWAIT_MARKER_O), .SSTK_EMPTY_O(SSTK_EMPTY_O));

//--- tb/cfg_pipe.sv
`timescale 1ns/1ps
module cfg_pipe
	import cfg_pkg::*;
(
	input  wire logic              clk_i,
	output cfg_pkg::cfg_instr_type instr_o
);
	initial instr_o = '0;
	task automatic send(input logic [3:0] c, input logic u, input logic [63:0] a, input logic p);
		@(posedge clk_i);
		instr_o <= {1'b1, c, u, a, p};
		@(posedge clk_i);
		// idle cycle: stale class, address and page fields scrambled, user kept
		instr_o <= {1'b0, ~c, u, ~a, ~p};
	endtask : send
endmodule : cfg_pipe

//--- tb/cfg_guard_bench.sv
`timescale 1ns/1ps
module cfg_guard_bench;
	import cfg_pkg::*;
	logic          ref_clk = 0;
	logic          nrst = 0;
	logic          en_u = 0;
	logic          en_s = 0;
	logic          ibt = 0;
	cfg_instr_type instr;
	cfg_report_type rep;
	logic          blk, rok, awt, emp;
	int            err_total = 0;
	int            checked = 0;
	always #20 ref_clk = ~ref_clk;
	cfg_pipe pipe (.clk_i(ref_clk), .instr_o(instr));
	cfg_guard #(.DEPTH(4)) dut (.REF_CLK_I(ref_clk), .NRST_I(nrst), .SSTK_EN_USER_I(en_u),
		.SSTK_EN_SUPER_I(en_s), .IBT_EN_I(ibt), .INSTR_I(instr), .REPORT_O(rep),
		.STORE_BLOCK_O(blk), .RETURN_OK_O(rok), .AWAIT_MARKER_O(awt), .SSTK_EMPTY_O(emp));
	task automatic ck(input string n, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask : ck
	task automatic go(input logic [3:0] c, input logic u, input logic [63:0] a, input logic p);
		pipe.send(c, u, a, p);
		#1;
	endtask : go
	task automatic t_track;
		@(posedge ref_clk) ibt <= 1'b1;
		go(4'h5, 0, 0, 0); ck("await", 1, awt);
		go(4'h0, 0, 0, 0); ck("report", 8'h0A, {rep.fault, rep.code});
		go(4'h6, 0, 0, 0); go(4'h7, 0, 0, 0); ck("rep_leg", 0, {rep.fault, awt});
		go(4'h5, 0, 0, 0); go(4'h8, 0, 0, 0); ck("rep_wide", 0, {rep.fault, awt});
	endtask : t_track
	task automatic t_stack;
		@(posedge ref_clk) en_s <= 1'b1;
		go(4'h1, 1, 64'hA000, 0); ck("empty_off", 1, emp);
		go(4'h1, 0, 64'hA000, 0); ck("empty", 0, emp);
		go(4'h4, 0, 64'hA000, 0); ck("ret_ok", 1, rok);
		ck("empty_pop", 1, emp);
		@(posedge ref_clk) en_u <= 1'b1;
		go(4'h2, 1, 64'hA000, 0); go(4'h4, 1, 64'hB000, 0);
		ck("ret_bad", 8'h09, {rep.fault, rep.code});
	endtask : t_stack
	task automatic t_limits;
		go(4'h4, 0, 64'hC000, 0); ck("under", 8'h0C, {rep.fault, rep.code});
		repeat (4) go(4'h3, 0, 64'hC000, 0);
		go(4'h1, 0, 64'hC000, 0); ck("over", 8'h0D, {rep.fault, rep.code});
		go(4'h5, 0, 0, 0); ck("await_mid", 1, awt);
		@(posedge ref_clk) nrst <= 1'b0;
		@(posedge ref_clk) nrst <= 1'b1;
		#1 ck("rst_mid", 8'h01, {awt, rep.fault, emp});
	endtask : t_limits
	task automatic t_store;
		go(4'h9, 0, 0, 1); ck("blk", 8'h1B, {blk, rep.fault, rep.code});
		go(4'h9, 0, 0, 0); ck("plain", 0, {blk, rep.fault});
	endtask : t_store
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (10) @(posedge ref_clk);
		#1 ck("rst", 8'h01, {awt, rep.fault, emp});
		@(posedge ref_clk) nrst <= 1'b1;
		t_track();
		t_stack();
		t_limits();
		t_store();
		report_and_stop();
	end
	initial begin
		repeat (500) @(posedge ref_clk);
		err_total++;
		report_and_stop();
	end
endmodule : cfg_guard_bench
